// ===== sld_consts.svh
/*
  shared constants of the lane sample deframer: rate window, multiframe
  length, slot counts.
  assumes inclusion by its bare name from the package and design files.
*/
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH

`define SLD_LANES         8
`define SLD_MAX_OCTETS    8
`define SLD_MAX_SLOTS     16
`define SLD_RATE_MIN_MBPS 16'h0bb8
`define SLD_RATE_MAX_MBPS 16'h3a98
`define SLD_K_LAST        5'h1f
`define SLD_NP_WIDE       5'h10
`define SLD_NP_DENSE      5'h0c
`define SLD_HD_FLAG       1'h1

`endif

// ===== sld_pkg.sv
/*
  types and the operating mode table of the lane sample deframer.
  assumes sld_consts.svh is on the include path.
*/
`include "sld_consts.svh"

package sld_pkg;

  typedef struct packed {
    logic       ok_single;
    logic       ok_dual;
    logic [3:0] lanes;
    logic [2:0] conv;
    logic [3:0] octets;
    logic [4:0] np;
    logic [4:0] res;
  } sld_mode_t;

  typedef logic [7:0][7:0]   sld_octets_t;
  typedef logic [15:0][15:0] sld_samples_t;

  // lanes, converters, octets per frame, container, resolution
  function automatic sld_mode_t sld_mode_info(input logic [4:0] m);
    sld_mode_t r;
    r = '0;
    case (m)
      5'h00:   r = '{1'h1, 1'h1, 4'h1, 3'h2, 4'h4, 5'h10, 5'h10};
      5'h01:   r = '{1'h1, 1'h1, 4'h2, 3'h4, 4'h4, 5'h10, 5'h10};
      5'h02:   r = '{1'h1, 1'h1, 4'h3, 3'h6, 4'h4, 5'h10, 5'h10};
      5'h03:   r = '{1'h1, 1'h1, 4'h2, 3'h2, 4'h2, 5'h10, 5'h10};
      5'h04:   r = '{1'h1, 1'h1, 4'h4, 3'h4, 4'h2, 5'h10, 5'h10};
      5'h05:   r = '{1'h1, 1'h1, 4'h1, 3'h2, 4'h3, 5'h0c, 5'h0c};
      5'h06:   r = '{1'h1, 1'h1, 4'h2, 3'h4, 4'h3, 5'h0c, 5'h0c};
      5'h07:   r = '{1'h1, 1'h1, 4'h1, 3'h4, 4'h8, 5'h10, 5'h10};
      5'h08:   r = '{1'h1, 1'h1, 4'h4, 3'h2, 4'h1, 5'h10, 5'h10};
      5'h09:   r = '{1'h1, 1'h1, 4'h4, 3'h2, 4'h2, 5'h10, 5'h10};
      5'h0d:   r = '{1'h1, 1'h1, 4'h4, 3'h2, 4'h1, 5'h10, 5'h0b};
      5'h0e:   r = '{1'h1, 1'h1, 4'h4, 3'h2, 4'h2, 5'h10, 5'h0b};
      5'h0f:   r = '{1'h1, 1'h0, 4'h8, 3'h2, 4'h1, 5'h10, 5'h0b};
      5'h10:   r = '{1'h1, 1'h0, 4'h8, 3'h2, 4'h2, 5'h10, 5'h0b};
      5'h11:   r = '{1'h1, 1'h0, 4'h8, 3'h2, 4'h3, 5'h0c, 5'h0b};
      default: r = '0;
    endcase
    return r;
  endfunction

endpackage

// ===== sld_sync_if.sv
/*
  carrier between the deframer and one link's sync monitor.
  assumes one instance per link, all in the i_ref_clk domain.
*/
`timescale 1ns/1ps

interface sld_sync_if;
  logic [7:0] lane_up;
  logic [3:0] lanes;
  logic       cfg_ok;
  logic       resync;

  modport ctl (output lane_up, output lanes, output cfg_ok, input resync);
  modport mon (input lane_up, input lanes, input cfg_ok, output resync);
endinterface

// ===== sld_link_sync.sv
/*
  per link sync monitor: one request bit for all lanes of the link.
  assumes lane_up bits are synchronous to i_ref_clk.
*/
`timescale 1ns/1ps

module sld_link_sync (
  input  logic       i_ref_clk,
  input  logic       i_rst,
  sld_sync_if.mon    sync
);

  logic resync_r;
  logic resync_nxt;

  // any used lane down, or bad config, requests resync
  always_comb
  begin
    resync_nxt = ~sync.cfg_ok;
    for (int l = 0; l < 8; l++)
    begin
      if (l < int'(sync.lanes) && !sync.lane_up[l])
      begin
        resync_nxt = 1'h1; // R04
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      resync_r <= 1'h1;
    else
      resync_r <= resync_nxt; // R03
  end

  assign sync.resync = resync_r;

  AST_LANE_LOSS: assert property ( // R04
    @(posedge i_ref_clk) disable iff (i_rst)
    (sync.lanes != 4'h0 && !sync.lane_up[0]) |=> resync_r)
    else $error("lane loss did not raise resync");

endmodule

// ===== sld_deframer.sv
/*
  receive transport deframer: lane octets to per converter samples,
  two links, with per link resync requests.
  assumes aligned, descrambled octets, one per lane per i_octet_valid.
*/
`timescale 1ns/1ps
`include "sld_consts.svh"

// Link rules this block follows or relies on
// R01: lane rate limited to 3 to 15 Gbps
// R02: lane rate follows M/L, NP, sample rate
// R03: one sync request output per link
// R04: lane losing alignment raises link resync
// R05: transmitter sends sync characters while requested
// R06: single link modes 0-9, 13-17
// R07: dual link modes 0-9, 13, 14
// R08: 32 frames per multiframe, dense format
// R09: container and resolution set per mode
// R10: octets per frame set per mode
// R11: samples per converter per frame per mode
// R12: modes 8, 13 split samples over lanes
// R13: mode 15 lane pairs, interleaved samples
// R14: mode 3 one converter per lane
// R15: mode 4 lane n is converter n
// R16: modes 9, 14 lane pairs interleave samples
// R17: mode 16 four lanes per converter
// R18: transmitter zeroes unused low container bits
// R19: mapping from mode; samples ascending order
// R20: dense modes carry three nibbles, msb first
module sld_deframer (
  input  logic                 i_ref_clk,
  input  logic                 i_rst,
  input  logic                 i_dual_link,
  input  logic [4:0]           i_mode_a,
  input  logic [4:0]           i_mode_b,
  input  logic [15:0]          i_lane_rate_mbps,
  input  logic [7:0]           i_lane_aligned,
  input  logic                 i_octet_valid,
  input  sld_pkg::sld_octets_t i_lane_octets,
  output logic                 o_link_a_resync_request,
  output logic                 o_link_b_resync_request,
  output logic                 o_mode_error,
  output logic                 o_rate_error,
  output sld_pkg::sld_samples_t o_link_a_samples,
  output logic                 o_link_a_sample_valid,
  output logic [4:0]           o_link_a_sample_count,
  output logic [4:0]           o_link_a_frame_num,
  output sld_pkg::sld_samples_t o_link_b_samples,
  output logic                 o_link_b_sample_valid,
  output logic [4:0]           o_link_b_sample_count,
  output logic [4:0]           o_link_b_frame_num
);

  ////////////////////////////////////////////////////////////////////////
  // mode decode and link supervision

  sld_pkg::sld_mode_t info [2];
  logic               ok_a;
  logic               ok_b;
  logic               rate_ok;
  logic               mode_err_r;
  logic               mode_err_nxt;
  logic               rate_err_r;
  logic               rate_err_nxt;
  logic [1:0]         hold;

  sld_sync_if sync_a ();
  sld_sync_if sync_b ();

  assign info[0] = sld_pkg::sld_mode_info(i_mode_a); // R19
  assign info[1] = sld_pkg::sld_mode_info(i_mode_b);
  assign ok_a    = i_dual_link ? info[0].ok_dual : info[0].ok_single; // R06
  assign ok_b    = info[1].ok_dual; // R07
  assign rate_ok = (i_lane_rate_mbps >= `SLD_RATE_MIN_MBPS) &&
                   (i_lane_rate_mbps <= `SLD_RATE_MAX_MBPS); // R01

  always_comb
  begin
    mode_err_nxt = ~ok_a | (i_dual_link & ~ok_b); // R07
    rate_err_nxt = ~rate_ok;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      mode_err_r <= 1'h0;
      rate_err_r <= 1'h0;
    end
    else
    begin
      mode_err_r <= mode_err_nxt;
      rate_err_r <= rate_err_nxt;
    end
  end

  // link b sits on lanes 4-7 and is idle in single link
  assign sync_a.lane_up = i_lane_aligned;
  assign sync_a.lanes   = info[0].lanes;
  assign sync_a.cfg_ok  = ok_a & rate_ok; // R01
  assign sync_b.lane_up = {4'hf, i_lane_aligned[7:4]};
  assign sync_b.lanes   = i_dual_link ? info[1].lanes : 4'h0;
  assign sync_b.cfg_ok  = ~i_dual_link | (ok_b & rate_ok);

  sld_link_sync u_sync_a (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .sync      (sync_a)
  );

  sld_link_sync u_sync_b (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .sync      (sync_b)
  );

  // while requested the far end sends sync characters; restart frame
  assign hold[0] = sync_a.resync; // R05
  assign hold[1] = sync_b.resync | ~i_dual_link;

  ////////////////////////////////////////////////////////////////////////
  // octet capture per lane, frame and multiframe counting

  logic [7:0] buf_r    [2][8][8];
  logic [7:0] buf_nxt  [2][8][8];
  logic [2:0] cnt_r    [2];
  logic [2:0] cnt_nxt  [2];
  logic [4:0] fnum_r   [2];
  logic [4:0] fnum_nxt [2];
  logic [1:0] done_r;
  logic [1:0] done_nxt;
  logic [7:0] src      [2][8];

  always_comb
  begin
    for (int l = 0; l < 8; l++)
    begin
      src[0][l] = i_lane_octets[l];
      src[1][l] = (l < 4) ? i_lane_octets[l ^ 4] : 8'h00;
    end
  end

  always_comb
  begin
    buf_nxt  = buf_r;
    cnt_nxt  = cnt_r;
    fnum_nxt = fnum_r;
    done_nxt = 2'h0;
    for (int k = 0; k < 2; k++)
    begin
      if (hold[k])
      begin
        cnt_nxt[k]  = 3'h0;
        fnum_nxt[k] = 5'h00;
      end
      else
      begin
        if (i_octet_valid)
        begin
          for (int l = 0; l < 8; l++)
            buf_nxt[k][l][cnt_r[k]] = src[k][l];
          if ({1'h0, cnt_r[k]} == info[k].octets - 4'h1) // R10
          begin
            cnt_nxt[k]  = 3'h0;
            done_nxt[k] = 1'h1;
          end
          else
            cnt_nxt[k] = cnt_r[k] + 3'h1;
        end
        if (done_r[k])
          fnum_nxt[k] = (fnum_r[k] == `SLD_K_LAST) ? 5'h00
                                                   : fnum_r[k] + 5'h01; // R08
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 2; k++)
      begin
        cnt_r[k]  <= 3'h0;
        fnum_r[k] <= 5'h00;
        for (int l = 0; l < 8; l++)
          for (int o = 0; o < 8; o++)
            buf_r[k][l][o] <= 8'h00;
      end
      done_r <= 2'h0;
    end
    else
    begin
      buf_r  <= buf_nxt;
      cnt_r  <= cnt_nxt;
      fnum_r <= fnum_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lanes joined lane 0 first, cut into NP bit slots, slot g is
  // converter g / per-converter count, samples ascending

  logic [7:0]            bytes   [2][64];
  sld_pkg::sld_samples_t smp_r   [2];
  sld_pkg::sld_samples_t smp_nxt [2];
  logic [4:0]            scnt_r  [2];
  logic [4:0]            scnt_nxt[2];
  logic [4:0]            snum_r  [2];
  logic [4:0]            snum_nxt[2];
  logic [1:0]            sval_r;
  logic [1:0]            sval_nxt;

  always_comb
  begin
    int nb;
    int n;
    logic [15:0] val;
    logic [15:0] mask;
    logic [3:0]  nib [3];
    nb = 0;
    n = 0;
    val = 16'h0000;
    mask = 16'h0000;
    nib = '{4'h0, 4'h0, 4'h0};
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 64; i++)
        bytes[k][i] = 8'h00;
      for (int l = 0; l < 8; l++)
        for (int o = 0; o < 8; o++)
          if (l < int'(info[k].lanes) && o < int'(info[k].octets))
            bytes[k][l * int'(info[k].octets) + o] = buf_r[k][l][o]; // R19
      nb = int'(info[k].lanes) * int'(info[k].octets);
      if (info[k].np == `SLD_NP_WIDE)
        scnt_nxt[k] = 5'(nb / 2); // R02 R11
      else
        scnt_nxt[k] = 5'((nb * 2) / 3);
      mask = ~(16'hffff >> info[k].res); // R09
      for (int g = 0; g < 16; g++)
      begin
        if (info[k].np == `SLD_NP_WIDE)
          val = {bytes[k][2 * g], bytes[k][2 * g + 1]}; // R12 R13 R14 R15 R16 R17
        else
        begin
          for (int j = 0; j < 3; j++)
          begin
            n = 3 * g + j;
            nib[j] = n[0] ? bytes[k][n / 2][3:0]
                          : bytes[k][n / 2][7:4]; // R20
          end
          val = {nib[0], nib[1], nib[2], 4'h0};
        end
        // low bits beyond resolution are zero from the far end
        smp_nxt[k][g] = (g < int'(scnt_nxt[k])) ? (val & mask)
                                                 : 16'h0000; // R18
      end
      sval_nxt[k] = done_r[k] & ~hold[k];
      snum_nxt[k] = sval_nxt[k] ? fnum_r[k] : snum_r[k];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 2; k++)
      begin
        smp_r[k]  <= '0;
        scnt_r[k] <= 5'h00;
        snum_r[k] <= 5'h00;
      end
      sval_r <= 2'h0;
    end
    else
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (sval_nxt[k])
        begin
          smp_r[k]  <= smp_nxt[k];
          scnt_r[k] <= scnt_nxt[k];
        end
        snum_r[k] <= snum_nxt[k];
      end
      sval_r <= sval_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_link_a_resync_request = sync_a.resync; // R03
  assign o_link_b_resync_request = sync_b.resync;
  assign o_mode_error            = mode_err_r;
  assign o_rate_error            = rate_err_r;
  assign o_link_a_samples        = smp_r[0];
  assign o_link_a_sample_valid   = sval_r[0];
  assign o_link_a_sample_count   = scnt_r[0];
  assign o_link_a_frame_num      = snum_r[0];
  assign o_link_b_samples        = smp_r[1];
  assign o_link_b_sample_valid   = sval_r[1];
  assign o_link_b_sample_count   = scnt_r[1];
  assign o_link_b_frame_num      = snum_r[1];

  ////////////////////////////////////////////////////////////////////////
  // checks

  AST_RATE_LOW: assert property ( // R01
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_lane_rate_mbps < `SLD_RATE_MIN_MBPS) |=> o_link_a_resync_request)
    else $error("low lane rate did not hold link a");

  AST_RATE_FLAG: assert property ( // R01
    @(posedge i_ref_clk) disable iff (i_rst)
    rate_ok |=> !o_rate_error)
    else $error("rate error raised for legal rate");

  AST_SINGLE_GAP: assert property ( // R06
    @(posedge i_ref_clk) disable iff (i_rst)
    (!i_dual_link && i_mode_a == 5'h0a) |=> o_mode_error)
    else $error("unsupported single link mode accepted");

  AST_DUAL_WIDE: assert property ( // R07
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_dual_link && i_mode_b == 5'h0f) |=> o_mode_error)
    else $error("eight lane mode accepted in dual link");

  AST_LINK_B_IDLE: assert property ( // R03
    @(posedge i_ref_clk) disable iff (i_rst)
    (!i_dual_link) [*2] |=> !o_link_b_resync_request)
    else $error("idle link b requested resync");

  AST_OCT_WRAP: assert property ( // R10
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_octet_valid && !hold[0] && i_mode_a == 5'h00 && cnt_r[0] == 3'h3)
    |=> (done_r[0] && cnt_r[0] == 3'h0))
    else $error("frame of four octets not closed");

  AST_FRAME_WRAP: assert property ( // R08
    @(posedge i_ref_clk) disable iff (i_rst)
    (done_r[0] && !hold[0] && fnum_r[0] == `SLD_K_LAST) |=> fnum_r[0] == 5'h00)
    else $error("multiframe did not wrap after 32 frames");

  AST_DENSE_COUNT: assert property ( // R11
    @(posedge i_ref_clk) disable iff (i_rst)
    (done_r[0] && !hold[0] && !i_dual_link && i_mode_a == 5'h11)
    |=> (o_link_a_sample_valid && o_link_a_sample_count == 5'h10))
    else $error("mode 17 frame did not yield 16 samples");

  AST_SPLIT_MAP: assert property ( // R12
    @(posedge i_ref_clk) disable iff (i_rst)
    (done_r[0] && !hold[0] && i_mode_a == 5'h08)
    |=> o_link_a_samples[0] == {$past(buf_r[0][0][0]), $past(buf_r[0][1][0])})
    else $error("mode 8 sample not joined from lanes 0 and 1");

endmodule

// ===== sld_tx_model.sv
/*
  transmitter model that feeds whole frames of lane octets.
  assumes the bench pushes frames only while no resync is requested.
*/
`timescale 1ns/1ps

module sld_tx_model #(
  parameter logic [7:0] SYNC_CHAR = 8'hbc
) (
  input  wire logic            i_ref_clk,
  input  wire logic            i_req_a,
  input  wire logic            i_req_b,
  output logic                 o_valid,
  output sld_pkg::sld_octets_t o_octets
);
  sld_pkg::sld_octets_t q [$];

  ////////////////////////////////////////////////////////////////////////////
  // slots packed lane after lane, msb first; d copies onto lanes 4-7
  task automatic send(input logic [15:0] s [16], input int l, input int f,
                      input int p, input int res, input logic d);
    sld_pkg::sld_octets_t w [8];
    logic [3:0]           nb [128];
    logic [15:0]          v;
    int                   n;
    n = 0;
    for (int g = 0; g < l * f * 8 / (p ? 12 : 16); g++)
    begin
      v = s[g] & (16'hffff << (16 - res));
      for (int k = 0; k < (p ? 3 : 4); k++)
      begin
        nb[n] = v[15 - 4 * k -: 4];
        n++;
      end
    end
    for (int k = 0; k < 8; k++)
      w[k] = {8{8'h5a ^ k[7:0]}};
    for (int j = 0; j < n / 2; j++)
    begin
      w[j % f][j / f] = {nb[2 * j], nb[2 * j + 1]};
      if (d)
        w[j % f][j / f + 4] = {nb[2 * j], nb[2 * j + 1]};
    end
    for (int k = 0; k < f; k++)
      q.push_back(w[k]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // sync characters while requested, queued data frames otherwise, o_valid low once the queue is empty
  always @(negedge i_ref_clk)
  begin
    if (i_req_a || i_req_b)
    begin
      q.delete();
      o_valid <= 1'h1;
      o_octets <= {8{SYNC_CHAR}};
    end
    else if (q.size() != 0)
    begin
      o_valid <= 1'h1;
      o_octets <= q.pop_front();
    end
    else
    begin
      o_valid <= 1'h0;
      o_octets <= ~o_octets;
    end
  end
endmodule

// ===== sld_deframer_bench.sv
/*
  self checking bench of the lane sample deframer.
  assumes the package, the design files and sld_tx_model compiled first.
*/
`timescale 1ns/1ps

module sld_deframer_bench;
  logic                  i_ref_clk = 1'h0;
  logic                  i_rst = 1'h1;
  logic                  dual = 1'h0;
  logic [4:0]            mode_a = 5'h00;
  logic [4:0]            mode_b = 5'h00;
  logic [15:0]           rate = 16'h1f40;
  logic [7:0]            algn = 8'hff;
  logic                  ov;
  sld_pkg::sld_octets_t  oct;
  logic                  req_a, req_b, merr, rerr, sv_a, sv_b;
  logic [4:0]            cnt_a, cnt_b, fn_a, fn_b;
  sld_pkg::sld_samples_t smp_a, smp_b;
  int                    bad_count = 0;
  int                    tests_run = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  sld_tx_model tx_u (
    .i_ref_clk (i_ref_clk),
    .i_req_a   (req_a),
    .i_req_b   (req_b),
    .o_valid   (ov),
    .o_octets  (oct)
  );

  sld_deframer dut_u (
    .i_ref_clk               (i_ref_clk),
    .i_rst                   (i_rst),
    .i_dual_link             (dual),
    .i_mode_a                (mode_a),
    .i_mode_b                (mode_b),
    .i_lane_rate_mbps        (rate),
    .i_lane_aligned          (algn),
    .i_octet_valid           (ov),
    .i_lane_octets           (oct),
    .o_link_a_resync_request (req_a),
    .o_link_b_resync_request (req_b),
    .o_mode_error            (merr),
    .o_rate_error            (rerr),
    .o_link_a_samples        (smp_a),
    .o_link_a_sample_valid   (sv_a),
    .o_link_a_sample_count   (cnt_a),
    .o_link_a_frame_num      (fn_a),
    .o_link_b_samples        (smp_b),
    .o_link_b_sample_valid   (sv_b),
    .o_link_b_sample_count   (cnt_b),
    .o_link_b_frame_num      (fn_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t flag %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t word %h want %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic summarize;
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // lanes, octets per frame, nibble packing, resolution
  function automatic logic [15:0] mtab(input logic [4:0] m);
    case (m)
      5'h00:   return {4'h1, 4'h4, 3'h0, 5'h10};
      5'h01:   return {4'h2, 4'h4, 3'h0, 5'h10};
      5'h02:   return {4'h3, 4'h4, 3'h0, 5'h10};
      5'h03:   return {4'h2, 4'h2, 3'h0, 5'h10};
      5'h04:   return {4'h4, 4'h2, 3'h0, 5'h10};
      5'h05:   return {4'h1, 4'h3, 3'h4, 5'h0c};
      5'h06:   return {4'h2, 4'h3, 3'h4, 5'h0c};
      5'h07:   return {4'h1, 4'h8, 3'h0, 5'h10};
      5'h08:   return {4'h4, 4'h1, 3'h0, 5'h10};
      5'h09:   return {4'h4, 4'h2, 3'h0, 5'h10};
      5'h0d:   return {4'h4, 4'h1, 3'h0, 5'h0b};
      5'h0e:   return {4'h4, 4'h2, 3'h0, 5'h0b};
      5'h0f:   return {4'h8, 4'h1, 3'h0, 5'h0b};
      5'h10:   return {4'h8, 4'h2, 3'h0, 5'h0b};
      default: return {4'h8, 4'h3, 3'h4, 5'h0b};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic run_mode(input logic [4:0] m, input logic d, input int n);
    logic [15:0] s [16];
    logic [15:0] e [40][16];
    logic [15:0] t;
    int          ns, i;
    t = mtab(m);
    ns = t[15:12] * t[11:8] * 8 / (t[7] ? 12 : 16);
    step(1);
    dual = d;
    mode_a = m;
    mode_b = m;
    algn = 8'h00;
    step(1);
    algn = 8'hff;
    i = 0;
    while ((req_a !== 1'h0 || (d && req_b !== 1'h0)) && i < 30)
    begin
      step(1);
      i++;
    end
    if (!d)
      chk_bit(req_b, 1'h0);
    for (int fr = 0; fr < n; fr++)
    begin
      for (int g = 0; g < 16; g++)
      begin
        s[g] = 16'h9e37 * (g + 1) ^ {fr[7:0], 3'h0, m};
        e[fr][g] = g < ns ? s[g] & (16'hffff << (16 - t[4:0])) : 16'h0;
      end
      tx_u.send(s, t[15:12], t[11:8], t[7], t[4:0], d);
    end
    for (int fr = 0; fr < n; fr++)
    begin
      i = 0;
      step(1);
      while (sv_a !== 1'h1 && i < 40)
      begin
        step(1);
        i++;
      end
      chk_bit(sv_a, 1'h1);
      chk_word({11'h0, cnt_a}, ns[15:0]);
      chk_word({11'h0, fn_a}, 16'(fr % 32));
      for (int g = 0; g < 16; g++)
        chk_word(smp_a[g], e[fr][g]);
      if (d)
      begin
        chk_bit(sv_b, 1'h1);
        chk_word({11'h0, cnt_b}, ns[15:0]);
        chk_word({11'h0, fn_b}, 16'(fr % 32));
        for (int g = 0; g < 16; g++)
          chk_word(smp_b[g], e[fr][g]);
      end
    end
  endtask

  task automatic t_modes;
    int sm [15] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 13, 14, 15, 16, 17};
    foreach (sm[i])
      run_mode(sm[i][4:0], 1'h0, sm[i] == 8 ? 34 : 2);
    for (int i = 0; i < 12; i++)
      run_mode(sm[i][4:0], 1'h1, 2);
  endtask

  task automatic t_lanes;
    run_mode(5'h03, 1'h1, 1);
    step(1);
    algn = 8'hf7;
    step(2);
    chk_bit(req_a, 1'h0);
    chk_bit(req_b, 1'h0);
    algn = 8'hd7;
    step(2);
    chk_bit(req_b, 1'h1);
    chk_bit(req_a, 1'h0);
    algn = 8'hfd;
    step(2);
    chk_bit(req_a, 1'h1);
    chk_bit(req_b, 1'h0);
    algn = 8'hff;
  endtask

  task automatic t_errors;
    int          bm [5] = '{10, 11, 12, 18, 31};
    logic [15:0] rt [4] = '{16'h0bb7, 16'h0bb8, 16'h3a98, 16'h3a99};
    foreach (bm[i])
    begin
      step(1);
      dual = 1'h0;
      mode_a = bm[i][4:0];
      step(2);
      chk_bit(merr, 1'h1);
      chk_bit(req_a, 1'h1);
    end
    step(1);
    dual = 1'h1;
    mode_a = 5'h00;
    mode_b = 5'h0f;
    step(2);
    chk_bit(merr, 1'h1);
    chk_bit(req_b, 1'h1);
    step(1);
    dual = 1'h0;
    foreach (rt[i])
    begin
      step(1);
      rate = rt[i];
      step(2);
      chk_bit(rerr, i == 0 || i == 3);
      chk_bit(req_a, i == 0 || i == 3);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial
  begin
    step(8);
    chk_bit(req_a, 1'h1);
    chk_bit(req_b, 1'h1);
    chk_bit(sv_a, 1'h0);
    step(1);
    i_rst = 1'h0;
    t_modes();
    t_lanes();
    t_errors();
    summarize();
  end

  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule
